// ==== hw/prio_consts.svh ====
// Constants for the interrupt source prioritizer
//
// Contract
// - Levels run 0 to 16, 16 highest; level 0 is masked, never forwarded.
// - Nonmaskable request always has fixed top level 16.
// - Nonmaskable request is edge detected, accepted only while block bit is 0.
// - In sleep or standby the nonmaskable request is accepted regardless of block bit.
// - Edge polarity select bit in control register picks nonmaskable edge.
// - Polarity 0 means falling edge (reset value); 1 means rising edge.
// - After a write changing polarity, ignore nonmaskable input for 20 cycles.
// - Taking any request never rewrites the CPU mask level field.
// - External level is 15 minus the active-low pin value; 1111 means none.
// - Level pins sampled each cycle; level taken after two equal samples.
// - In standby pins are filtered on the 32.768 kHz tick, else not recognised.
// - Peripheral requests come from timer, clock, serial, refresh and watchdog.
// - Each peripheral module level is a 4-bit field of a priority register.
// - Reset sets every peripheral level to zero, masking them all.
// - Ties go nonmaskable, external, then peripherals in code order.
// - Selected source reported by event code; nonmaskable 1C0, external 200..3C0.
// - Timer codes 400, 420, 440, capture 460 sharing third timer level.
// - A flag change with block bit 0 may yield a request with code 0.
// - Forward only when level is strictly greater than CPU mask level.
// - Accepted request drives the notify output pin low.
`ifndef PRIO_CONSTS_SVH
`define PRIO_CONSTS_SVH

`define ADDR_CTRL 8'hE0
`define ADDR_PRIO_A 8'hE2
`define ADDR_PRIO_B 8'hE4
`define ADDR_EVENT 8'hE6
`define ADDR_WINNER 8'hE8

`define CTRL_PIN_BIT 15
`define CTRL_POL_BIT 8
`define PRIO_RESET 16'h0000

`define HOLDOFF_CYCLES 5'd20
`define LVL_NMI 5'h10
`define LVL_NONE 5'h00
`define PINS_IDLE 4'hF

`define CODE_NMI 12'h1C0
`define CODE_EXT_TOP 12'h3E0
`define CODE_STEP 12'h020
`define CODE_NONE 12'h000

`define NUM_PERIPH 14

`endif

// ==== hw/prio_pkg.sv ====
// Types shared by the interrupt source prioritizer
package prio_pkg;

  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [11:0] code;
  } cpu_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Peripheral request lines, in default order
  typedef struct packed {
    logic tmr0_under;
    logic tmr1_under;
    logic tmr2_under;
    logic tmr2_capture;
    logic rtc_alarm;
    logic rtc_periodic;
    logic rtc_carry;
    logic ser_rx_error;
    logic ser_rx_full;
    logic ser_tx_empty;
    logic ser_tx_end;
    logic wdog_interval;
    logic ref_compare;
    logic ref_overflow;
  } periph_req_t;

endpackage : prio_pkg

// ==== hw/level_filter.sv ====
// Noise filter for the encoded external level pins
`timescale 1ns/1ps
`include "prio_consts.svh"
module level_filter
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sampling
  input wire logic sample_en,
  input wire logic [3:0] encoded_level_pins_n,
  // Result
  output logic [3:0] external_level_request
);

  logic [3:0] last_sample;
  logic [3:0] stable_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_sample <= `PINS_IDLE;
    else if (sample_en)
      last_sample <= encoded_level_pins_n;
  end

  // Accept a pattern only when two consecutive samples agree
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      stable_n <= `PINS_IDLE;
    else if (sample_en && encoded_level_pins_n == last_sample)
      stable_n <= encoded_level_pins_n;
  end

  assign external_level_request = `PINS_IDLE - stable_n;

  stable_two_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(stable_n) |-> $past(sample_en) && $past(encoded_level_pins_n) == $past(last_sample))
    else $error("level accepted without two equal samples");

endmodule : level_filter

// ==== hw/interrupt_source_prioritizer.sv ====
// Interrupt source prioritizer: edge, level and peripheral arbitration
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "prio_consts.svh"
module interrupt_source_prioritizer
  import prio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // External pins
  input wire logic nmi_pin,
  input wire logic [3:0] encoded_level_pins_n,
  output logic request_notify_out_n,
  // CPU state
  input wire logic block_bit,
  input wire logic [3:0] cpu_mask_level,
  input wire logic sleep_mode,
  input wire logic standby_mode,
  input wire logic rtc_tick,
  input wire logic cpu_ack,
  // Peripheral requests
  input wire periph_req_t periph_req,
  // Request to CPU
  output cpu_req_t cpu_req
);

  logic edge_polarity_select;
  logic [15:0] prio_a;
  logic [15:0] prio_b;
  logic [11:0] event_code;
  logic [4:0] holdoff;
  logic nmi_prev;
  logic nmi_edge;
  logic nmi_pend;
  logic nmi_ok;
  logic sample_en;
  logic [3:0] ext_level;
  logic [`NUM_PERIPH-1:0] preq;
  logic [3:0] plevel [`NUM_PERIPH];
  logic [4:0] next_level;
  logic [11:0] next_code;
  logic next_valid;
  logic ctrl_wr;

  // Module level field of a source index
  function automatic logic [3:0] field_of(input int idx, input logic [15:0] a,
                                          input logic [15:0] b);
    logic [3:0] f;
    f = 4'h0;
    case (idx)
      0: f = a[15:12];
      1: f = a[11:8];
      2, 3: f = a[7:4];
      4, 5, 6: f = a[3:0];
      7, 8, 9, 10: f = b[7:4];
      11: f = b[15:12];
      12, 13: f = b[11:8];
      default: f = 4'h0;
    endcase
    return f;
  endfunction : field_of

  // Event code of a source index
  function automatic logic [11:0] code_of(input int idx);
    logic [11:0] c;
    c = 12'h400;
    for (int k = 0; k < idx; k++)
      c = c + `CODE_STEP;
    return c;
  endfunction : code_of

  // Register file
  assign ctrl_wr = reg_req.wr && reg_req.addr == `ADDR_CTRL;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      edge_polarity_select <= 1'b0;
    else if (ctrl_wr)
      edge_polarity_select <= reg_req.wdata[`CTRL_POL_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prio_a <= `PRIO_RESET;
      prio_b <= `PRIO_RESET;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == `ADDR_PRIO_A)
        prio_a <= reg_req.wdata;
      if (reg_req.addr == `ADDR_PRIO_B)
        prio_b <= {reg_req.wdata[15:4], 4'h0};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        `ADDR_CTRL:
        begin
          reg_rdata <= 16'h0000;
          reg_rdata[`CTRL_PIN_BIT] <= nmi_pin;
          reg_rdata[`CTRL_POL_BIT] <= edge_polarity_select;
        end
        `ADDR_PRIO_A: reg_rdata <= prio_a;
        `ADDR_PRIO_B: reg_rdata <= prio_b;
        `ADDR_EVENT: reg_rdata <= {4'h0, event_code};
        `ADDR_WINNER: reg_rdata <= {cpu_req.valid, 10'h000, cpu_req.level};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Edge detection hold-off after a polarity change
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      holdoff <= 5'd0;
    else if (ctrl_wr && reg_req.wdata[`CTRL_POL_BIT] != edge_polarity_select)
      holdoff <= `HOLDOFF_CYCLES;
    else if (holdoff != 5'd0)
      holdoff <= holdoff - 5'd1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      nmi_prev <= 1'b1;
    else
      nmi_prev <= nmi_pin;
  end

  assign nmi_edge = holdoff == 5'd0 &&
                    (edge_polarity_select ? (nmi_pin && !nmi_prev)
                                          : (!nmi_pin && nmi_prev));

  assign nmi_ok = !block_bit || sleep_mode || standby_mode;

  // Pending edge; a new edge wins over the acknowledge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      nmi_pend <= 1'b0;
    else if (nmi_edge)
      nmi_pend <= 1'b1;
    else if (cpu_ack && cpu_req.valid && cpu_req.code == `CODE_NMI)
      nmi_pend <= 1'b0;
  end

  // External level filtering; slow tick only in standby
  assign sample_en = standby_mode ? rtc_tick : 1'b1;

  level_filter i_level_filter
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .encoded_level_pins_n(encoded_level_pins_n),
    .external_level_request(ext_level)
  );

  // Peripheral request lines and module levels
  assign preq = periph_req;

  genvar g;
  generate
    for (g = 0; g < `NUM_PERIPH; g++)
    begin : g_lvl
      assign plevel[g] = field_of(g, prio_a, prio_b);
    end
  endgenerate

  // Arbitration; strict compare keeps the earlier source on ties
  always_comb
  begin
    next_level = `LVL_NONE;
    next_code = `CODE_NONE;
    if (nmi_pend && nmi_ok)
    begin
      next_level = `LVL_NMI;
      next_code = `CODE_NMI;
    end
    else if (ext_level != 4'h0)
    begin
      next_level = {1'b0, ext_level};
      next_code = `CODE_EXT_TOP - {3'b000, ext_level, 5'b00000};
    end
    for (int i = 0; i < `NUM_PERIPH; i++)
    begin
      if (preq[`NUM_PERIPH-1-i] && {1'b0, plevel[i]} > next_level)
      begin
        next_level = {1'b0, plevel[i]};
        next_code = code_of(i);
      end
    end
    next_valid = next_level != `LVL_NONE &&
                 next_level > {1'b0, cpu_mask_level};
  end

  // Registered request; the mask field is only read, never written
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_req <= '0;
      request_notify_out_n <= 1'b1;
    end
    else
    begin
      cpu_req.valid <= next_valid;
      cpu_req.level <= next_level;
      cpu_req.code <= next_code;
      request_notify_out_n <= !next_valid;
    end
  end

  // Event code latched at acknowledge; a vanished request reads 0
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      event_code <= `CODE_NONE;
    else if (cpu_ack)
      event_code <= cpu_req.valid ? cpu_req.code : `CODE_NONE;
  end

  level_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cpu_req.valid |-> cpu_req.level != 5'h00)
    else $error("masked level forwarded");

  nmi_top_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (nmi_pend && !block_bit) |=> cpu_req.valid && cpu_req.level == 5'h10
      && cpu_req.code == 12'h1C0)
    else $error("nonmaskable request not on top");

  nmi_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (block_bit && !sleep_mode && !standby_mode) |=> cpu_req.code != 12'h1C0)
    else $error("nonmaskable request passed block bit");

  nmi_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (nmi_pend && sleep_mode) |=> cpu_req.level == 5'h10)
    else $error("nonmaskable request lost in sleep");

  holdoff_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctrl_wr && reg_req.wdata[`CTRL_POL_BIT] != edge_polarity_select)
      |=> holdoff == `HOLDOFF_CYCLES ##19 holdoff == 5'd1 && !nmi_edge)
    else $error("hold-off length wrong");

  holdoff_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    holdoff != 5'd0 |-> !nmi_edge)
    else $error("edge seen during hold-off");

  ext_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!nmi_pend && ext_level == 4'hF && cpu_mask_level != 4'hF) |=> cpu_req.level == 5'h0F
      && cpu_req.code == 12'h200)
    else $error("external level code wrong");

  mask_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cpu_req.valid |-> cpu_req.level > {1'b0, $past(cpu_mask_level)})
    else $error("request not above mask");

  notify_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    request_notify_out_n == !cpu_req.valid)
    else $error("notify pin disagrees with request");

  timer_tie_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (periph_req == 14'b00110000000000 && !nmi_pend && ext_level == 4'h0
      && prio_a[7:4] > cpu_mask_level) |=> cpu_req.code == 12'h440)
    else $error("underflow did not beat capture");

  reset_mask_a: assert property (@(posedge core_clk)
    $rose(rst_n) |-> prio_a == 16'h0000 && prio_b == 16'h0000)
    else $error("priorities not cleared by reset");

  // Edge detection, withheld request and notify pin checks
  pol_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (holdoff == 5'd0 && !edge_polarity_select && $fell(nmi_pin)) |=> nmi_pend)
    else $error("falling edge not taken");

  pol_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (holdoff == 5'd0 && edge_polarity_select && $rose(nmi_pin)) |=> nmi_pend)
    else $error("rising edge not taken");

  nmi_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (nmi_pend && block_bit && !sleep_mode && !standby_mode && !cpu_ack)
      |=> nmi_pend)
    else $error("withheld nonmaskable request lost");

  notify_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (nmi_pend && nmi_ok) |=> !request_notify_out_n)
    else $error("notify pin not low for accepted request");

  // Level decoding and filtering
  ext_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sample_en && $past(sample_en) && $past(rst_n) && $stable(encoded_level_pins_n))
      |=> ext_level == `PINS_IDLE - $past(encoded_level_pins_n))
    else $error("level pins decoded wrongly");

  tick_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (standby_mode && !rtc_tick) |=> $stable(ext_level))
    else $error("level recognised without slow tick");

  // Arbitration and event code
  all_masked_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!nmi_pend && ext_level == 4'h0 && prio_a == `PRIO_RESET && prio_b == `PRIO_RESET)
      |=> !cpu_req.valid)
    else $error("peripheral request passed level zero");

  tmr0_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (periph_req == 14'h2000 && !nmi_pend && ext_level == 4'h0
      && prio_a[15:12] > cpu_mask_level)
      |=> cpu_req.code == 12'h400 && cpu_req.level == {1'b0, $past(prio_a[15:12])})
    else $error("timer level or code wrong");

  ext_tie_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!nmi_pend && ext_level != 4'h0 && ext_level == prio_a[15:12] && periph_req == 14'h2000
      && ext_level > cpu_mask_level) |=> cpu_req.code < 12'h400)
    else $error("peripheral beat external level on a tie");

  spurious_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cpu_ack && !cpu_req.valid) |=> event_code == `CODE_NONE)
    else $error("vanished request did not read zero");

  event_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cpu_ack && cpu_req.valid) |=> event_code == $past(cpu_req.code))
    else $error("event code not latched at acknowledge");

endmodule : interrupt_source_prioritizer

// ==== verification/cpu_core_model.sv ====
// CPU-side partner model: acknowledges forwarded requests after a set delay
`timescale 1ns/1ps
module cpu_core_model
  import prio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Request from the prioritizer
  input wire cpu_req_t cpu_req,
  // Behaviour control
  input wire logic [3:0] ack_delay,
  input wire logic stray_ack,
  // Acknowledge
  output logic cpu_ack
);
  logic [3:0] wait_cnt;
  logic ready;
  assign ready = cpu_req.valid && !cpu_ack && (wait_cnt >= ack_delay);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_cnt <= 4'h0;
      cpu_ack <= 1'h0;
    end
    else
    begin
      // A stray acknowledge with nothing pending must latch a zero code
      cpu_ack <= ready || stray_ack;
      wait_cnt <= (cpu_req.valid && !cpu_ack && !ready) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : cpu_core_model

// ==== verification/tb_interrupt_source_prioritizer.sv ====
// Self-checking testbench for the interrupt source prioritizer
`timescale 1ns/1ps
`include "prio_consts.svh"
`define CHK(got, want) check_count++; if ((got) !== (want)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, got, want); end
module tb_interrupt_source_prioritizer
  import prio_pkg::*;
;
  typedef struct packed {
    logic [3:0] pins;
    logic [15:0] pa;
    logic [15:0] pb;
    logic [13:0] per;
    logic [3:0] mask;
    logic v;
    logic [4:0] lvl;
    logic [11:0] code;
  } row_t;
  logic core_clk, rst_n, nmi_pin, request_notify_out_n, block_bit, sleep_mode;
  logic standby_mode, rtc_tick, cpu_ack, stray_ack;
  logic [3:0] encoded_level_pins_n, cpu_mask_level, ack_delay;
  logic [15:0] reg_rdata, rd_val;
  reg_req_t reg_req;
  periph_req_t periph_req;
  cpu_req_t cpu_req;
  int n_errors, check_count;
  row_t rows [14] = '{
    '{4'hF, 16'h0000, 16'h0000, 14'h2000, 4'h0, 1'h0, 5'h00, 12'h000},
    '{4'h0, 16'h0000, 16'h0000, 14'h0000, 4'h0, 1'h1, 5'h0F, 12'h200},
    '{4'hE, 16'h0000, 16'h0000, 14'h0000, 4'h0, 1'h1, 5'h01, 12'h3C0},
    '{4'hF, 16'h5000, 16'h0000, 14'h2000, 4'h0, 1'h1, 5'h05, 12'h400},
    '{4'hF, 16'h3300, 16'h0000, 14'h3000, 4'h0, 1'h1, 5'h03, 12'h400},
    '{4'hF, 16'h0070, 16'h0000, 14'h0C00, 4'h0, 1'h1, 5'h07, 12'h440},
    '{4'hF, 16'h0070, 16'h0000, 14'h0400, 4'h0, 1'h1, 5'h07, 12'h460},
    '{4'hA, 16'h5000, 16'h0000, 14'h2000, 4'h0, 1'h1, 5'h05, 12'h340},
    '{4'hA, 16'h0000, 16'h0000, 14'h0000, 4'h5, 1'h0, 5'h00, 12'h000},
    '{4'hA, 16'h0000, 16'h0000, 14'h0000, 4'h4, 1'h1, 5'h05, 12'h340},
    '{4'hF, 16'h0009, 16'h0000, 14'h0200, 4'h8, 1'h1, 5'h09, 12'h480},
    '{4'hF, 16'h0000, 16'h0040, 14'h0008, 4'h0, 1'h1, 5'h04, 12'h540},
    '{4'hF, 16'h0000, 16'hF000, 14'h0004, 4'hE, 1'h1, 5'h0F, 12'h560},
    '{4'hF, 16'h0000, 16'h0200, 14'h0001, 4'h1, 1'h1, 5'h02, 12'h5A0}};

  interrupt_source_prioritizer i_interrupt_source_prioritizer (.core_clk, .rst_n, .reg_req,
    .reg_rdata, .nmi_pin, .encoded_level_pins_n, .request_notify_out_n, .block_bit,
    .cpu_mask_level, .sleep_mode, .standby_mode, .rtc_tick, .cpu_ack, .periph_req, .cpu_req);
  cpu_core_model i_cpu_core_model (.core_clk, .rst_n, .cpu_req, .ack_delay, .stray_ack,
    .cpu_ack);

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{a, d, 1'h1, 1'h0};
    @(posedge core_clk);
    reg_req.wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{a, 16'h0000, 1'h0, 1'h1};
    @(posedge core_clk);
    reg_req.rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : reg_rd

  task automatic set_prio(input logic [15:0] pa, input logic [15:0] pb);
    logic [15:0] d;
    @(posedge core_clk);
    block_bit <= 1'h1;
    reg_wr(`ADDR_PRIO_A, pa);
    reg_wr(`ADDR_PRIO_B, pb);
    reg_rd(`ADDR_PRIO_A, d);
    `CHK(d, pa)
    @(posedge core_clk);
    block_bit <= 1'h0;
  endtask : set_prio

  task automatic exp_req(input logic v, input logic [4:0] lvl, input logic [11:0] code);
    #1;
    `CHK(cpu_req.valid, v)
    `CHK(request_notify_out_n, !v)
    if (v)
    begin
      `CHK(cpu_req.level, lvl)
      `CHK(cpu_req.code, code)
    end
  endtask : exp_req

  task automatic hold_quiet(input int n);
    repeat (n)
    begin
      @(posedge core_clk) #1;
      `CHK(cpu_req.valid, 1'h0)
    end
  endtask : hold_quiet

  task automatic wait_valid(input int n);
    for (int k = 0; k < n && cpu_req.valid !== 1'h1; k++)
      @(posedge core_clk) #1;
    if (cpu_req.valid !== 1'h1)
    begin
      n_errors++;
      $display("unexpected at %0t: request never raised", $time);
      give_verdict();
    end
  endtask : wait_valid

  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    {rst_n, reg_req, block_bit, cpu_mask_level, sleep_mode, standby_mode} = '0;
    {rtc_tick, periph_req, ack_delay, stray_ack, n_errors, check_count} = '0;
    nmi_pin = 1'h1;
    encoded_level_pins_n = 4'hF;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    reg_rd(`ADDR_CTRL, rd_val);
    `CHK(rd_val, 16'h8000)
    reg_rd(`ADDR_PRIO_A, rd_val);
    `CHK(rd_val, 16'h0000)
    reg_rd(`ADDR_PRIO_B, rd_val);
    `CHK(rd_val, 16'h0000)
    reg_rd(8'h10, rd_val);
    `CHK(rd_val, 16'h0000)
    set_prio(16'h0000, 16'hFFFF);
    reg_rd(`ADDR_PRIO_B, rd_val);
    `CHK(rd_val, 16'hFFF0)
    foreach (rows[i])
    begin
      block_bit <= 1'h1;
      periph_req <= rows[i].per;
      set_prio(rows[i].pa, rows[i].pb);
      encoded_level_pins_n <= rows[i].pins;
      cpu_mask_level <= rows[i].mask;
      repeat (5) @(posedge core_clk);
      exp_req(rows[i].v, rows[i].lvl, rows[i].code);
      reg_rd(`ADDR_WINNER, rd_val);
      `CHK(rd_val & {1'h1, 10'h000, {5{rows[i].v}}}, {rows[i].v, 10'h000, rows[i].lvl})
    end
    @(posedge core_clk);
    {periph_req, cpu_mask_level} <= '0;
    repeat (4) @(posedge core_clk);
    encoded_level_pins_n <= 4'h0;
    @(posedge core_clk);
    encoded_level_pins_n <= 4'hF;
    hold_quiet(6);
    @(posedge core_clk);
    standby_mode <= 1'h1;
    encoded_level_pins_n <= 4'h0;
    hold_quiet(8);
    repeat (3)
    begin
      @(posedge core_clk);
      rtc_tick <= 1'h1;
      @(posedge core_clk);
      rtc_tick <= 1'h0;
      repeat (2) @(posedge core_clk);
    end
    wait_valid(6);
    exp_req(1'h1, 5'h0F, 12'h200);
    @(posedge core_clk);
    {standby_mode, encoded_level_pins_n} <= {1'h0, 4'hF};
    repeat (6) @(posedge core_clk);
    // Edge request above a level 15 pin request; slow acknowledge
    {ack_delay, encoded_level_pins_n, nmi_pin} <= {4'hF, 4'h0, 1'h0};
    wait_valid(4);
    exp_req(1'h1, 5'h10, `CODE_NMI);
    repeat (20) @(posedge core_clk);
    reg_rd(`ADDR_EVENT, rd_val);
    `CHK(rd_val, 16'h01C0)
    exp_req(1'h1, 5'h0F, 12'h200);
    // Keep the level 15 request until the slow acknowledge has taken it
    repeat (12) @(posedge core_clk);
    reg_rd(`ADDR_EVENT, rd_val);
    `CHK(rd_val, 16'h0200)
    @(posedge core_clk);
    {ack_delay, encoded_level_pins_n, block_bit, nmi_pin} <= {4'h0, 4'hF, 2'h3};
    repeat (8) @(posedge core_clk);
    nmi_pin <= 1'h0;
    hold_quiet(6);
    @(posedge core_clk);
    {sleep_mode, nmi_pin} <= 2'h3;
    @(posedge core_clk);
    nmi_pin <= 1'h0;
    wait_valid(6);
    exp_req(1'h1, 5'h10, `CODE_NMI);
    @(posedge core_clk);
    {sleep_mode, block_bit} <= 2'h0;
    repeat (8) @(posedge core_clk);
    reg_wr(`ADDR_CTRL, 16'h0100);
    repeat (4) @(posedge core_clk);
    nmi_pin <= 1'h1;
    repeat (5) @(posedge core_clk);
    nmi_pin <= 1'h0;
    hold_quiet(12);
    reg_rd(`ADDR_CTRL, rd_val);
    `CHK(rd_val, 16'h0100)
    @(posedge core_clk);
    nmi_pin <= 1'h1;
    wait_valid(4);
    exp_req(1'h1, 5'h10, `CODE_NMI);
    repeat (8) @(posedge core_clk);
    stray_ack <= 1'h1;
    @(posedge core_clk);
    stray_ack <= 1'h0;
    reg_rd(`ADDR_EVENT, rd_val);
    `CHK(rd_val, 16'h0000)
    give_verdict();
  end
endmodule : tb_interrupt_source_prioritizer
